// ===== inc/spmux_params.svh
// constants for the switch port pin mux
`ifndef SPMUX_PARAMS_SVH
`define SPMUX_PARAMS_SVH
`define SPMUX_MODE_W 3
`define SPMUX_MODE_MII_MAC 3'h0
`define SPMUX_MODE_MII_PHY 3'h1
`define SPMUX_MODE_RMII_MAC 3'h3
`define SPMUX_MODE_RMII_PHY 3'h2
`define SPMUX_MODE_INT_PHY 3'h6
`define SPMUX_MODE_RESET 3'h6
`define SPMUX_FIFO_W 3
`define SPMUX_FIFO_D 16
`define SPMUX_MDC_DIV 4'h4
`endif

// ===== inc/spmux_pkg.sv
// types for the switch port pin mux
package spmux_pkg;
   // port mode, gray coded along the usual path
   typedef enum logic [2:0] {
      SPMUX_MII_MAC = 3'h0,
      SPMUX_MII_PHY = 3'h1,
      SPMUX_RMII_PHY = 3'h2,
      SPMUX_RMII_MAC = 3'h3,
      SPMUX_INT_PHY = 3'h6
   } spmux_mode_type;
endpackage

// ===== rtl/spmux_fifo.sv
// small fifo carrying sampled port 1 input data
`timescale 1ns/10ps
module spmux_fifo #(
   parameter int WIDTH = 3,
   parameter int DEPTH = 16
) (
   input wire logic core_clk_i,
   input wire logic reset_n_i,
   input wire logic clk_en_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH]; // storage array
   logic [AW-1:0] wr_ptr; // write index
   logic [AW-1:0] rd_ptr; // read index
   logic [AW:0] count; // words held
   wire do_wr = in_valid_i && in_ready_o;
   wire do_rd = out_valid_o && out_ready_i;
   assign in_ready_o = (count != DEPTH[AW:0]); // honest full
   assign out_valid_o = (count != '0); // honest empty
   assign out_data_o = mem[rd_ptr];
   // storage write, no reset needed
   always_ff @(posedge core_clk_i) begin
      if (clk_en_i && do_wr) begin
         mem[wr_ptr] <= in_data_i;
      end
   end
   // pointer and count update
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else if (clk_en_i) begin
         if (do_wr) wr_ptr <= wr_ptr + 1'b1;
         if (do_rd) rd_ptr <= rd_ptr + 1'b1;
         count <= count + {{AW{1'b0}}, do_wr} - {{AW{1'b0}}, do_rd};
      end
   end
endmodule // spmux_fifo

// ===== rtl/spmux_top.sv
// pin function selection for port 0 mii side pins and port 1 input data
// Notes on behaviour
// - mii mac: collision pin is input
// - mii phy: drive collision, off under isolate
// - mii mac: carrier sense pin is input
// - mii phy: drive carrier, off under isolate
// - rmii modes: collision, carrier, data3-2 unused
// - mgmt slave: data pin bidirectional with master
// - mgmt master: data pin exchanges with phys
// - mgmt master: device drives clock out
// - data line idles high, drivers release
// - straps captured once, on the third edge after reset release
// - mii mac: data3-1 receive nibble in
// - mii phy: data in, buffer off isolate
// - rmii mac: data1 receive bit in
// - rmii phy: data1 in, off under isolate
// - internal phy: data3-1 unused
`timescale 1ns/10ps
`include "spmux_params.svh"
module spmux_top (
   input wire logic core_clk_i,
   input wire logic reset_n_i,
   input wire logic clk_en_i,
   // straps and control
   input wire logic [2:0] mode_strap_i,
   input wire logic mgmt_master_strap_i,
   input wire logic virtual_phy_isolate_bit_i,
   // switch side port 0 status toward external mac
   input wire logic sw_collision_i,
   input wire logic sw_carrier_i,
   // switch side management master and slave requests
   input wire logic mgmt_drive_i,
   input wire logic mgmt_data_i,
   input wire logic mgmt_slave_drive_i,
   input wire logic mgmt_slave_data_i,
   // port 0 pins
   input wire logic port0_collision_pin_i,
   output logic port0_collision_pin_o,
   output logic port0_collision_pin_oe_o,
   input wire logic port0_carrier_sense_pin_i,
   output logic port0_carrier_sense_pin_o,
   output logic port0_carrier_sense_pin_oe_o,
   input wire logic port0_mgmt_data_pin_i,
   output logic port0_mgmt_data_pin_o,
   output logic port0_mgmt_data_pin_oe_o,
   input wire logic port0_mgmt_clock_pin_i,
   output logic port0_mgmt_clock_pin_o,
   output logic port0_mgmt_clock_pin_oe_o,
   // port 1 input data pins
   input wire logic port1_in_data_bit3_i,
   input wire logic port1_in_data_bit2_i,
   input wire logic port1_in_data_bit1_i,
   output logic port1_in_pulldown_en_o,
   // switch side results
   output logic sw_collision_o,
   output logic sw_carrier_o,
   output logic mgmt_data_o,
   output logic mgmt_clock_rise_o,
   output logic [2:0] port_mode_o,
   output logic mgmt_master_o,
   // port 1 data stream out of the fifo
   output logic p1_data_valid_o,
   input wire logic p1_data_ready_i,
   output logic [2:0] p1_data_o,
   output logic p1_overflow_o
);
   // two-stage synchronisers for all pins and straps
   logic [10:0] sync1; // first stage, read only by sync2
   logic [10:0] sync2; // second stage, safe to use
   logic strap_done; // straps taken once after release
   logic [1:0] strap_wait; // edges until the synchroniser holds real strap levels
   spmux_pkg::spmux_mode_type mode; // captured port mode
   logic mgmt_master; // captured management role
   logic mdc_prev; // last synced mgmt clock level
   logic [3:0] mdc_div; // divider for the driven clock
   logic mdc_out; // driven management clock level
   logic [2:0] p1_prev; // last sampled port 1 data
   logic ovf; // sticky overflow of the data fifo
   wire [10:0] pins_raw = {mode_strap_i, mgmt_master_strap_i,
      port0_collision_pin_i, port0_carrier_sense_pin_i, port0_mgmt_data_pin_i,
      port0_mgmt_clock_pin_i, port1_in_data_bit3_i, port1_in_data_bit2_i,
      port1_in_data_bit1_i};
   wire [2:0] s_strap = sync2[10:8];
   wire s_mstr = sync2[7];
   wire s_col = sync2[6];
   wire s_crs = sync2[5];
   wire s_mdio = sync2[4];
   wire s_mdc = sync2[3];
   wire [2:0] s_p1 = sync2[2:0];

   // mode decode
   wire is_mii_mac = (mode == spmux_pkg::SPMUX_MII_MAC);
   wire is_mii_phy = (mode == spmux_pkg::SPMUX_MII_PHY);
   wire is_rmii_mac = (mode == spmux_pkg::SPMUX_RMII_MAC);
   wire is_rmii_phy = (mode == spmux_pkg::SPMUX_RMII_PHY);
   wire iso = virtual_phy_isolate_bit_i;
   // phy modes gate the port 1 input buffer under isolate
   wire p1_buf_on = is_mii_mac || is_rmii_mac || ((is_mii_phy || is_rmii_phy) && !iso);
   wire p1_mii = is_mii_mac || is_mii_phy; // all three bits used
   wire p1_rmii = is_rmii_mac || is_rmii_phy; // bit 1 only
   wire [2:0] p1_mask = p1_mii ? 3'h7 : (p1_rmii ? 3'h1 : 3'h0); // internal phy none
   wire [2:0] p1_sample = s_p1 & p1_mask & {3{p1_buf_on}};
   wire p1_change = p1_buf_on && (p1_mask != 3'h0) && (p1_sample != p1_prev);
   wire fifo_in_ready;
   // pin directions
   wire next_col_oe = is_mii_phy && !iso;
   wire next_crs_oe = is_mii_phy && !iso;
   wire next_col_in = is_mii_mac ? s_col : 1'b0;
   wire next_crs_in = is_mii_mac ? s_crs : 1'b0;
   // data driven at the requested level when asserting, released otherwise, pull-up idles it high
   wire drv_req = mgmt_master ? mgmt_drive_i : mgmt_slave_drive_i;
   wire drv_dat = mgmt_master ? mgmt_data_i : mgmt_slave_data_i;
   wire next_mdio_oe = drv_req;
   wire next_mdio_o = drv_dat;
   wire next_mdc_rise = !mgmt_master && s_mdc && !mdc_prev; // external clock edge
   wire div_wrap = (mdc_div == `SPMUX_MDC_DIV - 4'h1);

   // synchroniser chain
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         sync1 <= 11'h000;
         sync2 <= 11'h000;
      end else if (clk_en_i) begin
         sync1 <= pins_raw;
         sync2 <= sync1;
      end
   end

   // straps taken once the synchroniser has filled after release, then held
   // sync2 still holds reset zeros for two edges, so taking it earlier would read a false mode
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         strap_wait <= 2'h0;
         strap_done <= 1'b0;
         mode <= spmux_pkg::SPMUX_INT_PHY;
         mgmt_master <= 1'b0;
      end else if (clk_en_i && !strap_done) begin
         if (strap_wait != 2'h2) begin
            strap_wait <= strap_wait + 2'h1; // pin levels still moving through the chain
         end else begin
            strap_done <= 1'b1;
            mode <= spmux_pkg::spmux_mode_type'(s_strap);
            mgmt_master <= s_mstr;
         end
      end
   end

   // management clock: sample external or divide own
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         mdc_prev <= 1'b0;
         mdc_div <= 4'h0;
         mdc_out <= 1'b0;
      end else if (clk_en_i) begin
         mdc_prev <= s_mdc;
         mdc_div <= div_wrap ? 4'h0 : mdc_div + 4'h1;
         if (mgmt_master && div_wrap) mdc_out <= !mdc_out;
         else if (!mgmt_master) mdc_out <= 1'b0;
      end
   end

   // registered pin outputs and switch side results
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         port0_collision_pin_o <= 1'b0;
         port0_collision_pin_oe_o <= 1'b0;
         port0_carrier_sense_pin_o <= 1'b0;
         port0_carrier_sense_pin_oe_o <= 1'b0;
         port0_mgmt_data_pin_o <= 1'b1;
         port0_mgmt_data_pin_oe_o <= 1'b0;
         port0_mgmt_clock_pin_o <= 1'b0;
         port0_mgmt_clock_pin_oe_o <= 1'b0;
         port1_in_pulldown_en_o <= 1'b0;
         sw_collision_o <= 1'b0;
         sw_carrier_o <= 1'b0;
         mgmt_data_o <= 1'b1;
         mgmt_clock_rise_o <= 1'b0;
      end else if (clk_en_i) begin
         port0_collision_pin_o <= sw_collision_i;
         port0_collision_pin_oe_o <= next_col_oe;
         port0_carrier_sense_pin_o <= sw_carrier_i;
         port0_carrier_sense_pin_oe_o <= next_crs_oe;
         port0_mgmt_data_pin_o <= next_mdio_o;
         port0_mgmt_data_pin_oe_o <= next_mdio_oe;
         port0_mgmt_clock_pin_o <= mdc_out;
         port0_mgmt_clock_pin_oe_o <= mgmt_master;
         port1_in_pulldown_en_o <= p1_buf_on && (p1_mask != 3'h0);
         sw_collision_o <= next_col_in;
         sw_carrier_o <= next_crs_in;
         mgmt_data_o <= next_mdio_oe ? next_mdio_o : s_mdio;
         mgmt_clock_rise_o <= next_mdc_rise;
      end
   end

   // port 1 data change capture; overflow sticks when the fifo is full
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         p1_prev <= 3'h0;
         ovf <= 1'b0;
      end else if (clk_en_i) begin
         p1_prev <= p1_sample;
         if (p1_change && !fifo_in_ready) ovf <= 1'b1;
      end
   end

   assign port_mode_o = mode;
   assign mgmt_master_o = mgmt_master;
   assign p1_overflow_o = ovf;

   // data fifo; outputs come from its registered state
   spmux_fifo #(
      .WIDTH(`SPMUX_FIFO_W),
      .DEPTH(`SPMUX_FIFO_D)
   ) u_fifo (
      .core_clk_i(core_clk_i),
      .reset_n_i(reset_n_i),
      .clk_en_i(clk_en_i),
      .in_valid_i(p1_change),
      .in_ready_o(fifo_in_ready),
      .in_data_i(p1_sample),
      .out_valid_o(p1_data_valid_o),
      .out_ready_i(p1_data_ready_i),
      .out_data_o(p1_data_o)
   );
endmodule // spmux_top

// ===== verif/spmux_far_end.sv
// behavioural external phy or mac plus management master
`timescale 1ns/10ps
module spmux_far_end (
   input wire logic core_clk_i,
   output logic far_col_o = 1'b0,
   output logic far_crs_o = 1'b0,
   output logic [2:0] far_nib_o = 3'h0,
   output logic far_mdc_o = 1'b0,
   output logic far_md_oe_o = 1'b0,
   output logic far_md_o = 1'b0
);
   // status and data bits move just after an edge, then stand
   task automatic put(input logic [2:0] nib, input logic col, input logic crs);
      @(posedge core_clk_i);
      far_nib_o <= nib;
      far_col_o <= col;
      far_crs_o <= crs;
   endtask
   // clock runs only inside a frame, data released at its end
   task automatic frame(input int bits);
      #130; // keeps the link clock off the core clock phase
      for (int k = 0; k < bits; k++) begin
         far_md_oe_o = 1'b1;
         far_md_o = k[0];
         #400 far_mdc_o = 1'b1;
         #400 far_mdc_o = 1'b0;
      end
      far_md_oe_o = 1'b0;
   endtask
endmodule // spmux_far_end

// ===== verif/spmux_top_sva.sv
// port level assertions for the switch port pin mux
`timescale 1ns/10ps
module spmux_top_sva (
   input wire logic core_clk_i,
   input wire logic reset_n_i,
   input wire logic virtual_phy_isolate_bit_i,
   input wire logic sw_collision_i,
   input wire logic mgmt_drive_i,
   input wire logic mgmt_slave_drive_i,
   input wire logic port0_collision_pin_i,
   input wire logic port0_collision_pin_o,
   input wire logic port0_collision_pin_oe_o,
   input wire logic port0_carrier_sense_pin_oe_o,
   input wire logic port0_mgmt_data_pin_oe_o,
   input wire logic port0_mgmt_clock_pin_o,
   input wire logic port0_mgmt_clock_pin_oe_o,
   input wire logic port1_in_pulldown_en_o,
   input wire logic sw_collision_o,
   input wire logic sw_carrier_o,
   input wire logic [2:0] port_mode_o,
   input wire logic mgmt_master_o,
   input wire logic p1_data_valid_o,
   input wire logic [2:0] p1_data_o
);
   // single domain; the mode guards keep checks off the capture edge
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!reset_n_i);
   chk_col_mac_in: assert property (port_mode_o == 3'h0 && $past(port_mode_o, 4) == 3'h0 |->
      sw_collision_o == $past(port0_collision_pin_i, 3) && !port0_collision_pin_oe_o) else $error("col input lost");
   chk_phy_status_out: assert property (port_mode_o == 3'h1 && $past(port_mode_o) == 3'h1 |->
      port0_collision_pin_oe_o == !$past(virtual_phy_isolate_bit_i) && port0_carrier_sense_pin_oe_o == port0_collision_pin_oe_o
      && (!port0_collision_pin_oe_o || port0_collision_pin_o == $past(sw_collision_i))) else $error("status drive wrong");
   chk_rmii_unused: assert property (port_mode_o[2:1] == 2'h1 && $past(port_mode_o[2:1]) == 2'h1 |->
      !(port0_collision_pin_oe_o | port0_carrier_sense_pin_oe_o | sw_collision_o | sw_carrier_o)
      && !(p1_data_valid_o && p1_data_o[2:1] != 2'h0)) else $error("rmii pin used");
   chk_mdc_master_out: assert property (mgmt_master_o && $past(mgmt_master_o, 8) |->
      port0_mgmt_clock_pin_oe_o && port0_mgmt_clock_pin_o != $past(port0_mgmt_clock_pin_o, 4)) else $error("mdc stuck");
   chk_mdc_slave_in: assert property (!mgmt_master_o |-> !port0_mgmt_clock_pin_oe_o)
      else $error("mdc driven as slave");
   chk_mdio_drive: assert property ($past(reset_n_i) |->
      port0_mgmt_data_pin_oe_o == $past(mgmt_master_o ? mgmt_drive_i : mgmt_slave_drive_i)) else $error("mdio enable wrong");
   chk_pd_isolate: assert property (port_mode_o inside {3'h1, 3'h2} && $stable(port_mode_o) |->
      port1_in_pulldown_en_o == !$past(virtual_phy_isolate_bit_i)) else $error("pulldown vs isolate");
   chk_strap_held: assert property ($past(reset_n_i, 4) |-> $stable(port_mode_o) && $stable(mgmt_master_o))
      else $error("straps moved");
endmodule // spmux_top_sva
bind spmux_top spmux_top_sva spmux_top_sva_i (.*);

// ===== verif/switch_port_mii_pin_mux_tb.sv
// self-checking bench for the switch port pin mux
`timescale 1ns/10ps
module switch_port_mii_pin_mux_tb;
   logic core_clk_i = 1'b0, reset_n_i = 1'b0, clk_en_i = 1'b1;
   logic [2:0] mode_strap_i = 3'h6;
   logic mgmt_master_strap_i = 1'b0, virtual_phy_isolate_bit_i = 1'b0, sw_collision_i = 1'b0, sw_carrier_i = 1'b0;
   logic mgmt_drive_i = 1'b0, mgmt_data_i = 1'b0, mgmt_slave_drive_i = 1'b0, mgmt_slave_data_i = 1'b0;
   logic p1_data_ready_i = 1'b1;
   wire logic port0_collision_pin_i, port0_carrier_sense_pin_i, port0_mgmt_data_pin_i, port0_mgmt_clock_pin_i;
   wire logic port1_in_data_bit3_i, port1_in_data_bit2_i, port1_in_data_bit1_i;
   logic port0_collision_pin_o, port0_collision_pin_oe_o, port0_carrier_sense_pin_o, port0_carrier_sense_pin_oe_o;
   logic port0_mgmt_data_pin_o, port0_mgmt_data_pin_oe_o, port0_mgmt_clock_pin_o, port0_mgmt_clock_pin_oe_o;
   logic port1_in_pulldown_en_o, sw_collision_o, sw_carrier_o, mgmt_data_o, mgmt_clock_rise_o, mgmt_master_o;
   logic [2:0] port_mode_o, p1_data_o, far_nib_o;
   logic p1_data_valid_o, p1_overflow_o, far_col_o, far_crs_o, far_mdc_o, far_md_oe_o, far_md_o;
   int err_count = 0, total_checks = 0;
   // wire levels from all drivers; the data line has a pull-up
   assign port0_collision_pin_i = port0_collision_pin_oe_o ? port0_collision_pin_o : far_col_o;
   assign port0_carrier_sense_pin_i = port0_carrier_sense_pin_oe_o ? port0_carrier_sense_pin_o : far_crs_o;
   assign port0_mgmt_clock_pin_i = port0_mgmt_clock_pin_oe_o ? port0_mgmt_clock_pin_o : far_mdc_o;
   assign port0_mgmt_data_pin_i = port0_mgmt_data_pin_oe_o ? port0_mgmt_data_pin_o : (far_md_oe_o ? far_md_o : 1'b1);
   assign {port1_in_data_bit3_i, port1_in_data_bit2_i, port1_in_data_bit1_i} = far_nib_o;
   spmux_top spmux_top_i (.*);
   spmux_far_end spmux_far_end_i (.*);
   always #50 core_clk_i = ~core_clk_i;
   // compare, count, report a miss
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk_i);
   endtask
   // reset with new straps; pins parked low so no stale change is queued
   task automatic restart(input logic [2:0] mode, input logic mst);
      spmux_far_end_i.put(3'h0, 1'b0, 1'b0);
      mode_strap_i <= mode;
      mgmt_master_strap_i <= mst;
      reset_n_i <= 1'b0;
      cyc(10);
      reset_n_i <= 1'b1;
      cyc(3);
      mode_strap_i <= 3'h7;
      cyc(3);
      check("mode", {mgmt_master_o, port_mode_o}, {mst, mode});
   endtask
   // mac mode status in, then overfill the fifo and drain it
   task automatic t_mii_mac;
      int n;
      restart(3'h0, 1'b0);
      spmux_far_end_i.put(3'h0, 1'b1, 1'b0);
      cyc(4);
      check("col", {sw_collision_o, sw_carrier_o, port0_collision_pin_oe_o}, 3'h4);
      p1_data_ready_i <= 1'b0;
      for (int k = 1; k < 19; k++) spmux_far_end_i.put(k[2:0], 1'b0, 1'b1);
      cyc(5);
      check("fill", {p1_overflow_o, p1_data_valid_o, sw_carrier_o, p1_data_o}, 6'h39);
      p1_data_ready_i <= 1'b1;
      n = 0;
      repeat (24) begin
         @(negedge core_clk_i);
         if (p1_data_valid_o === 1'b1) n++;
      end
      check("drain", 8'(n), 8'h10);
   endtask
   // phy mode drives status; isolate drops drivers and input capture
   task automatic t_mii_phy;
      restart(3'h1, 1'b0);
      sw_collision_i <= 1'b1;
      sw_carrier_i <= 1'b1;
      p1_data_ready_i <= 1'b0;
      spmux_far_end_i.put(3'h6, 1'b0, 1'b0);
      cyc(5);
      check("drive", {port0_collision_pin_oe_o, port0_collision_pin_o, port0_carrier_sense_pin_oe_o}, 3'h7);
      check("tx", {port1_in_pulldown_en_o, p1_data_valid_o, p1_data_o}, 5'h1E);
      check("crs out", port0_carrier_sense_pin_o, 1'b1);
      sw_carrier_i <= 1'b0;
      virtual_phy_isolate_bit_i <= 1'b1;
      p1_data_ready_i <= 1'b1;
      spmux_far_end_i.put(3'h1, 1'b0, 1'b0);
      cyc(5);
      check("iso", {port0_collision_pin_oe_o, port0_carrier_sense_pin_oe_o, port1_in_pulldown_en_o}, 3'h0);
      check("iso rx", p1_data_valid_o, 1'b0);
      virtual_phy_isolate_bit_i <= 1'b0;
   endtask
   // rmii keeps bit1 only; internal phy ignores every bit
   task automatic t_rmii;
      restart(3'h3, 1'b0);
      p1_data_ready_i <= 1'b0;
      spmux_far_end_i.put(3'h7, 1'b1, 1'b1);
      cyc(5);
      check("rmac", {sw_collision_o, sw_carrier_o, port0_collision_pin_oe_o, p1_data_valid_o, p1_data_o}, 7'h09);
      restart(3'h2, 1'b0);
      virtual_phy_isolate_bit_i <= 1'b1;
      spmux_far_end_i.put(3'h1, 1'b0, 1'b0);
      cyc(5);
      check("rphy", {port1_in_pulldown_en_o, p1_data_valid_o, port0_collision_pin_oe_o}, 3'h0);
      virtual_phy_isolate_bit_i <= 1'b0;
      restart(3'h6, 1'b0);
      spmux_far_end_i.put(3'h5, 1'b0, 1'b0);
      cyc(5);
      check("int", p1_data_valid_o, 1'b0);
      p1_data_ready_i <= 1'b1;
   endtask
   // slave frame from outside, slave drive, then master clock out
   task automatic t_mgmt;
      int n;
      restart(3'h0, 1'b0);
      n = 0;
      fork
         spmux_far_end_i.frame(6);
         repeat (60) begin
            @(negedge core_clk_i);
            if (mgmt_clock_rise_o === 1'b1) n++;
         end
      join
      check("rises", 8'(n), 8'h06);
      check("idle", {port0_mgmt_clock_pin_oe_o, port0_mgmt_data_pin_i}, 2'h1);
      @(posedge core_clk_i);
      mgmt_slave_drive_i <= 1'b1;
      cyc(4);
      check("slave", {port0_mgmt_data_pin_oe_o, port0_mgmt_data_pin_i, mgmt_data_o}, 3'h4);
      mgmt_slave_drive_i <= 1'b0;
      cyc(4);
      check("release", port0_mgmt_data_pin_i, 1'b1);
      restart(3'h0, 1'b1);
      mgmt_drive_i <= 1'b1;
      mgmt_data_i <= 1'b1;
      n = 0;
      repeat (32) begin
         @(negedge core_clk_i);
         if (port0_mgmt_clock_pin_i === 1'b1) n++;
      end
      check("mdc", 8'(n), 8'h10);
      check("master", {port0_mgmt_clock_pin_oe_o, port0_mgmt_data_pin_oe_o, port0_mgmt_data_pin_i}, 3'h7);
   endtask
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      t_mii_mac();
      t_mii_phy();
      t_rmii();
      t_mgmt();
      tally_and_finish();
   end
endmodule // switch_port_mii_pin_mux_tb
